// ---- rcsio_pkg.sv ----
package rcsio_pkg;

  // Clock and serial timing.
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned BAUD           = 2400;
  localparam int unsigned BIT_CYC        = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC       = BIT_CYC / 2;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned STOP_BITS      = 1;

  // Command characters.
  localparam logic [7:0] CHR_A  = 8'h41;
  localparam logic [7:0] CHR_S  = 8'h53;
  localparam logic [7:0] CHR_L  = 8'h4C;
  localparam logic [7:0] CHR_R  = 8'h52;
  localparam logic [7:0] CHR_M  = 8'h4D;
  localparam logic [7:0] CHR_H  = 8'h48;
  localparam logic [7:0] CHR_CR = 8'h0D;

  // Range codes and reset values.
  localparam logic [1:0] RANGE_LOW    = 2'h0;
  localparam logic [1:0] RANGE_MEDIUM = 2'h1;
  localparam logic [1:0] RANGE_HIGH   = 2'h2;
  localparam logic [1:0] RANGE_RST    = 2'h0;
  localparam int unsigned CONC_W      = 16;

  // Decoded serial commands.
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_AUTOSPAN,
    CMD_RETURN_TO_ANALYSIS,
    CMD_MANUAL_RANGE_LOW,
    CMD_MANUAL_RANGE_MEDIUM,
    CMD_MANUAL_RANGE_HIGH
  } rcsio_cmd_t;

  // Configuration of one threshold alarm.
  typedef struct packed {
    logic              enable;
    logic              low_trip;
    logic              failsafe;
    logic              latching;
    logic [CONC_W-1:0] threshold;
  } rcsio_alarm_cfg_t;

endpackage

// ---- rcsio_top.sv ----
`timescale 1ns/100ps
module rcsio_top
  import rcsio_pkg::*;
(
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_I,
  input  wire logic              SPAN_REQ_I,
  input  wire logic              START_MEAS_I,
  input  wire logic              RXD_I,
  input  wire logic              SUPPLY_FAULT_I,
  input  wire logic              POWER_KEY_I,
  input  wire logic              RESUME_KEY_I,
  input  wire logic              SPAN_DONE_I,
  input  wire logic              FILL_DONE_I,
  input  wire logic              MEAS_DONE_I,
  input  wire logic              RESULT_VALID_I,
  input  wire logic [CONC_W-1:0] CONC_I,
  input  wire rcsio_alarm_cfg_t  ALARM1_CFG_I,
  input  wire rcsio_alarm_cfg_t  ALARM2_CFG_I,
  input  wire logic              ALARM_ACK_I,
  output logic                   ALARM1_COIL_O,
  output logic                   ALARM2_COIL_O,
  output logic                   SYS_ALARM_COIL_O,
  output logic                   POWERED_O,
  output logic                   CAL_BUSY_O,
  output logic [2:0]             RANGE_CONTACT_O,
  output logic                   VALVE_O,
  output logic                   IDLE_CONTACT_O,
  output logic                   MSG_SEND_O
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree.
  logic [2:0] s_span, s_start, s_rxd;
  logic       span_lvl, start_lvl, rxd_lvl;
  logic       next_span_lvl, next_start_lvl, next_rxd_lvl;

  // Accept a new level only when the last two stages agree.
  always_comb begin
    next_span_lvl  = (s_span[1] == s_span[2]) ? s_span[2] : span_lvl;
    next_start_lvl = (s_start[1] == s_start[2]) ? s_start[2] : start_lvl;
    next_rxd_lvl   = (s_rxd[1] == s_rxd[2]) ? s_rxd[2] : rxd_lvl;
  end

  // Register the synchroniser chains.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      s_span    <= 3'h0;
      s_start   <= 3'h0;
      s_rxd     <= 3'h7;
      span_lvl  <= 1'b0;
      start_lvl <= 1'b0;
      rxd_lvl   <= 1'b1;
    end else begin
      s_span    <= {s_span[1:0], SPAN_REQ_I};
      s_start   <= {s_start[1:0], START_MEAS_I};
      s_rxd     <= {s_rxd[1:0], RXD_I};
      span_lvl  <= next_span_lvl;
      start_lvl <= next_start_lvl;
      rxd_lvl   <= next_rxd_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial receiver, 8N1 at the fixed bit rate.
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rcsio_rx_t;
  rcsio_rx_t  rx_st, next_rx_st;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [2:0]  rx_bit, next_rx_bit;
  logic [7:0]  rx_sh, next_rx_sh;
  logic        rx_vld, next_rx_vld;

  // Sample mid-bit; a bad stop bit drops the character.
  always_comb begin
    next_rx_st  = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh  = rx_sh;
    next_rx_vld = 1'b0;
    case (rx_st)
      RX_IDLE: begin
        next_rx_cnt = 16'h0;
        if (!rxd_lvl) begin
          next_rx_st = RX_START;
        end
      end
      RX_START: begin
        next_rx_cnt = rx_cnt + 16'h1;
        if (rx_cnt == 16'(HALF_CYC)) begin
          next_rx_cnt = 16'h0;
          next_rx_bit = 3'h0;
          next_rx_st  = rxd_lvl ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        next_rx_cnt = rx_cnt + 16'h1;
        if (rx_cnt == 16'(BIT_CYC - 1)) begin
          next_rx_cnt = 16'h0;
          next_rx_sh  = {rxd_lvl, rx_sh[7:1]};
          next_rx_bit = rx_bit + 3'h1;
          if (rx_bit == 3'(DATA_BITS - 1)) begin
            next_rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        next_rx_cnt = rx_cnt + 16'h1;
        if (rx_cnt == 16'(BIT_CYC - 1)) begin
          next_rx_vld = rxd_lvl;
          next_rx_st  = RX_IDLE;
        end
      end
      default: next_rx_st = RX_IDLE;
    endcase
  end

  // Register the receiver.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rx_st  <= RX_IDLE;
      rx_cnt <= 16'h0;
      rx_bit <= 3'h0;
      rx_sh  <= 8'h0;
      rx_vld <= 1'b0;
    end else begin
      rx_st  <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh  <= next_rx_sh;
      rx_vld <= next_rx_vld;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command parser: two letters then carriage return.
  logic [7:0]  c0, c1, next_c0, next_c1;
  logic [1:0]  n_chr, next_n_chr;
  rcsio_cmd_t  cmd;

  // Map a letter pair to a command.
  function automatic rcsio_cmd_t decode_cmd(input logic [7:0] a,
                                            input logic [7:0] b);
    decode_cmd = CMD_NONE;
    if (a == CHR_A && b == CHR_S) decode_cmd = CMD_AUTOSPAN;
    if (a == CHR_A && b == CHR_L) decode_cmd = CMD_RETURN_TO_ANALYSIS;
    if (a == CHR_R && b == CHR_L) decode_cmd = CMD_MANUAL_RANGE_LOW;
    if (a == CHR_R && b == CHR_M) decode_cmd = CMD_MANUAL_RANGE_MEDIUM;
    if (a == CHR_R && b == CHR_H) decode_cmd = CMD_MANUAL_RANGE_HIGH;
  endfunction

  // Keep the last two letters; a return with other than two is dropped.
  always_comb begin
    next_c0    = c0;
    next_c1    = c1;
    next_n_chr = n_chr;
    cmd        = CMD_NONE;
    if (rx_vld) begin
      if (rx_sh == CHR_CR) begin
        if (n_chr == 2'h2) begin
          cmd = decode_cmd(c0, c1);
        end
        next_n_chr = 2'h0;
      end else begin
        next_c0    = c1;
        next_c1    = rx_sh;
        next_n_chr = (n_chr == 2'h3) ? 2'h3 : n_chr + 2'h1;
      end
    end
  end

  // Register the parser.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      c0    <= 8'h0;
      c1    <= 8'h0;
      n_chr <= 2'h0;
    end else begin
      c0    <= next_c0;
      c1    <= next_c1;
      n_chr <= next_n_chr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Span calibration, range select, measure-once sequence.
  typedef enum logic [1:0] {MS_IDLE, MS_FILL, MS_MEAS} rcsio_ms_t;
  logic       span_busy, next_span_busy;
  logic [1:0] range, next_range;
  rcsio_ms_t  ms_st, next_ms_st;
  logic       start_prev, next_msg;

  // Span, range and one-shot control.
  always_comb begin
    next_span_busy = span_busy;
    next_range     = range;
    next_ms_st     = ms_st;
    next_msg       = 1'b0;
    if (!span_busy) begin
      if (span_lvl || cmd == CMD_AUTOSPAN) begin
        next_span_busy = 1'b1;
      end
    end else if (cmd == CMD_RETURN_TO_ANALYSIS) begin
      next_span_busy = 1'b0;
    end else if (SPAN_DONE_I) begin
      next_span_busy = span_lvl;
    end
    case (cmd)
      CMD_MANUAL_RANGE_LOW:    next_range = RANGE_LOW;
      CMD_MANUAL_RANGE_MEDIUM: next_range = RANGE_MEDIUM;
      CMD_MANUAL_RANGE_HIGH:   next_range = RANGE_HIGH;
      default:                 next_range = range;
    endcase
    case (ms_st)
      MS_IDLE: if (start_lvl && !start_prev) next_ms_st = MS_FILL;
      MS_FILL: if (FILL_DONE_I) next_ms_st = MS_MEAS;
      MS_MEAS: begin
        if (MEAS_DONE_I) begin
          next_ms_st = MS_IDLE;
          next_msg   = 1'b1;
        end
      end
      default: next_ms_st = MS_IDLE;
    endcase
  end

  // Register the control state.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      span_busy  <= 1'b0;
      range      <= RANGE_RST;
      ms_st      <= MS_IDLE;
      start_prev <= 1'b0;
      MSG_SEND_O <= 1'b0;
    end else begin
      span_busy  <= next_span_busy;
      range      <= next_range;
      ms_st      <= next_ms_st;
      start_prev <= start_lvl;
      MSG_SEND_O <= next_msg;
    end
  end

  // Contacts and valve from control state.
  assign CAL_BUSY_O     = span_busy;
  assign VALVE_O        = (ms_st == MS_FILL);
  assign IDLE_CONTACT_O = (ms_st == MS_IDLE);

  // One contact per range, closed only for the active range.
  for (genvar g = 0; g < 3; g++) begin : g_rng
    assign RANGE_CONTACT_O[g] = (range == 2'(g));
  end

  //////////////////////////////////////////////////////////////////////////////
  // Threshold alarms and latched system alarm.
  rcsio_alarm_cfg_t cfg [2];
  logic [1:0] trip, next_trip;
  logic       sys_trip, next_sys_trip, powered, next_powered;
  assign cfg[0] = ALARM1_CFG_I;
  assign cfg[1] = ALARM2_CFG_I;

  // Evaluate alarms on each new result; latched alarms hold until disabled or acked in a cycle without a new result.
  always_comb begin
    next_trip = trip;
    for (int i = 0; i < 2; i++) begin
      if (!cfg[i].enable) begin
        next_trip[i] = 1'b0;
      end else if (RESULT_VALID_I) begin
        if (cfg[i].low_trip ? (CONC_I < cfg[i].threshold)
                            : (CONC_I > cfg[i].threshold)) begin
          next_trip[i] = 1'b1;
        end else if (!cfg[i].latching) begin
          next_trip[i] = 1'b0;
        end
      end
      if (cfg[i].latching && ALARM_ACK_I && !RESULT_VALID_I) begin
        next_trip[i] = 1'b0;
      end
    end
    next_sys_trip = sys_trip | SUPPLY_FAULT_I;
    next_powered  = powered;
    if (powered && POWER_KEY_I) begin
      next_powered  = 1'b0;
      next_sys_trip = SUPPLY_FAULT_I;
    end else if (!powered && POWER_KEY_I && RESUME_KEY_I) begin
      next_powered = 1'b1;
    end
  end

  // Register the alarm state.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      trip     <= 2'h0;
      sys_trip <= 1'b0;
      powered  <= 1'b1;
    end else begin
      trip     <= next_trip;
      sys_trip <= next_sys_trip;
      powered  <= next_powered;
    end
  end

  // Coil drive: failsafe coils are energised when not in alarm.
  assign ALARM1_COIL_O    = cfg[0].failsafe ? ~trip[0] : trip[0];
  assign ALARM2_COIL_O    = cfg[1].failsafe ? ~trip[1] : trip[1];
  assign SYS_ALARM_COIL_O = ~sys_trip;
  assign POWERED_O        = powered;

endmodule

// ---- rcsio_monitor.sv ----
`timescale 1ns/100ps
module rcsio_monitor
  import rcsio_pkg::*;
(
  input wire logic              REF_CLK_I,
  input wire logic              RST_I,
  input wire logic              SPAN_REQ_I,
  input wire logic              SPAN_DONE_I,
  input wire logic              SUPPLY_FAULT_I,
  input wire logic              POWER_KEY_I,
  input wire logic              RESULT_VALID_I,
  input wire logic [CONC_W-1:0] CONC_I,
  input wire rcsio_alarm_cfg_t  ALARM1_CFG_I,
  input wire logic              ALARM1_COIL_O,
  input wire logic              SYS_ALARM_COIL_O,
  input wire logic              CAL_BUSY_O,
  input wire logic [2:0]        RANGE_CONTACT_O,
  input wire logic              VALVE_O,
  input wire logic              IDLE_CONTACT_O,
  input wire logic              MSG_SEND_O
);
  logic       req_q;
  logic [2:0] req_run;
  // Counts how long the span request has held one level.
  always_ff @(posedge REF_CLK_I) begin
    req_q <= SPAN_REQ_I;
    if (RST_I || SPAN_REQ_I != req_q) begin
      req_run <= 3'h0;
    end else if (req_run != 3'h7) begin
      req_run <= req_run + 3'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Sampling edge and reset shared by every check.
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  property p_take; (SPAN_REQ_I && !CAL_BUSY_O) [*7] |-> 1'b0; endproperty
  a_take: assert property (p_take)
    else $error("Span request was not taken.");
  property p_end; SPAN_DONE_I && CAL_BUSY_O && !SPAN_REQ_I && req_run > 3'h4
    |=> !CAL_BUSY_O; endproperty
  a_end: assert property (p_end)
    else $error("Busy contact did not reopen.");
  property p_again; SPAN_DONE_I && CAL_BUSY_O && SPAN_REQ_I && req_run > 3'h4
    |=> CAL_BUSY_O; endproperty
  a_again: assert property (p_again)
    else $error("Held request did not repeat the span.");
  property p_range; $onehot(RANGE_CONTACT_O); endproperty
  a_range: assert property (p_range)
    else $error("Range contacts are not one-hot.");
  property p_fill; $fell(IDLE_CONTACT_O) |-> VALVE_O; endproperty
  a_fill: assert property (p_fill)
    else $error("Measurement cycle did not open with the fill phase.");
  property p_idle; MSG_SEND_O |-> IDLE_CONTACT_O && !VALVE_O; endproperty
  a_idle: assert property (p_idle)
    else $error("Message sent before the cycle returned to idle.");
  property p_msg; MSG_SEND_O |=> !MSG_SEND_O; endproperty
  a_msg: assert property (p_msg)
    else $error("Message trigger longer than one cycle.");
  property p_off; !ALARM1_CFG_I.enable && $stable(ALARM1_CFG_I)
    |-> ALARM1_COIL_O == ALARM1_CFG_I.failsafe; endproperty
  a_off: assert property (p_off)
    else $error("Disabled alarm is active.");
  property p_sys; SUPPLY_FAULT_I |=> !SYS_ALARM_COIL_O; endproperty
  a_sys: assert property (p_sys)
    else $error("Supply fault did not trip the system alarm.");
  property p_hold; !SYS_ALARM_COIL_O && !POWER_KEY_I |=> !SYS_ALARM_COIL_O;
  endproperty
  a_hold: assert property (p_hold)
    else $error("System alarm cleared without power key.");
  property p_trip; RESULT_VALID_I && ALARM1_CFG_I.enable
    && !ALARM1_CFG_I.low_trip && CONC_I > ALARM1_CFG_I.threshold
    |=> ALARM1_COIL_O != ALARM1_CFG_I.failsafe; endproperty
  a_trip: assert property (p_trip)
    else $error("High alarm did not trip on a new result.");
endmodule
bind rcsio_top rcsio_monitor u_mon (.REF_CLK_I, .RST_I, .SPAN_REQ_I,
  .SPAN_DONE_I, .SUPPLY_FAULT_I, .POWER_KEY_I, .RESULT_VALID_I, .CONC_I,
  .ALARM1_CFG_I, .ALARM1_COIL_O, .SYS_ALARM_COIL_O, .CAL_BUSY_O,
  .RANGE_CONTACT_O, .VALVE_O, .IDLE_CONTACT_O, .MSG_SEND_O);

// ---- rcsio_far_end.sv ----
`timescale 1ns/100ps
module rcsio_far_end
  import rcsio_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic cal_busy_i,
  output logic      rxd_o,
  output logic      span_req_o,
  output logic      span_valve_o
);
  // Line idles high and no span is requested.
  initial begin
    rxd_o = 1'b1;
    span_req_o = 1'b0;
  end
  // The span gas valve opens only while the analyzer spans.
  assign span_valve_o = cal_busy_i;
  //////////////////////////////////////////////////////////////////////////////
  // Sends one character, start bit, data lsb first, then stop bit.
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
  // Requests a span, releasing it once the busy contact closes.
  task automatic span();
    while (cal_busy_i !== 1'b0) @(posedge clk_i);
    span_req_o <= 1'b1;
    while (cal_busy_i !== 1'b1) @(posedge clk_i);
    span_req_o <= 1'b0;
  endtask
  // Sets the request level directly, for out-of-turn requests.
  task automatic req(input logic l);
    span_req_o <= l;
  endtask
endmodule

// ---- remote_control_status_io_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module remote_control_status_io_tb;
  import rcsio_pkg::*;
  logic clk, rst, start, ack, rxd, req, busy, valve, idle, msg, a1, a2, sys;
  logic pwr, t, spv;
  logic [6:0] pls;
  logic [2:0] rng;
  logic [CONC_W-1:0] conc;
  logic [CONC_W-1:0] cv [3] = '{16'h2000, 16'h0800, 16'h1000};
  rcsio_alarm_cfg_t cfg;
  int num_errors = 0;
  int compares = 0;
  int n;
  rcsio_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .SPAN_REQ_I(req),
    .START_MEAS_I(start), .RXD_I(rxd), .SUPPLY_FAULT_I(pls[4]),
    .POWER_KEY_I(pls[5]), .RESUME_KEY_I(pls[6]), .SPAN_DONE_I(pls[0]),
    .FILL_DONE_I(pls[1]), .MEAS_DONE_I(pls[2]), .RESULT_VALID_I(pls[3]),
    .CONC_I(conc), .ALARM1_CFG_I(cfg), .ALARM2_CFG_I(cfg), .ALARM_ACK_I(ack),
    .ALARM1_COIL_O(a1), .ALARM2_COIL_O(a2), .SYS_ALARM_COIL_O(sys),
    .POWERED_O(pwr), .CAL_BUSY_O(busy), .RANGE_CONTACT_O(rng),
    .VALVE_O(valve), .IDLE_CONTACT_O(idle), .MSG_SEND_O(msg));
  rcsio_far_end u_far (.clk_i(clk), .cal_busy_i(busy), .rxd_o(rxd),
    .span_req_o(req), .span_valve_o(spv));
  //////////////////////////////////////////////////////////////////////////////
  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Raises the selected one-cycle strobes.
  task automatic pulse(input logic [6:0] m);
    pls <= m;
    tick(1);
    pls <= 7'h00;
  endtask
  task automatic close_out();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Sends two letters and a carriage return over the serial line.
  task automatic command(input logic [7:0] a, input logic [7:0] b);
    u_far.send_char(a);
    u_far.send_char(b);
    u_far.send_char(CHR_CR);
  endtask
  // Cuts a hung run short; five serial commands need about 63 ms.
  initial begin
    #80000000;
    num_errors++;
    close_out();
  end
  // Main sequence of tests.
  initial begin
    rst = 1'b1;
    pls = 7'h00;
    start = 1'b0;
    ack = 1'b0;
    conc = 16'h0000;
    cfg = '0;
    tick(5);
    rst <= 1'b0;
    tick(2);
    `CHK("range", 3'h1, rng)
    `CHK("idle", 1'b1, idle)
    u_far.span();
    tick(10);
    pulse(7'h01);
    tick(2);
    `CHK("busy", 1'b0, busy)
    u_far.req(1'b1);
    tick(10);
    `CHK("busy", 1'b1, busy)
    pulse(7'h01);
    tick(2);
    `CHK("busy", 1'b1, busy)
    u_far.req(1'b0);
    tick(10);
    u_far.req(1'b1);
    tick(2);
    u_far.req(1'b0);
    tick(10);
    pulse(7'h01);
    tick(10);
    `CHK("busy", 1'b0, busy)
    start <= 1'b1;
    tick(2);
    start <= 1'b0;
    tick(6);
    `CHK("valve", 1'b1, valve)
    `CHK("idle", 1'b0, idle)
    pulse(7'h02);
    tick(2);
    `CHK("valve", 1'b0, valve)
    pulse(7'h04);
    n = 0;
    repeat (6) begin
      tick(1);
      if (msg === 1'b1) n++;
    end
    `CHK("msgs", 1, n)
    `CHK("idle", 1'b1, idle)
    for (int i = 0; i < 8; i++) begin
      cfg <= {i[0], i[1], i[2], 1'b0, 16'h1000};
      for (int j = 0; j < 3; j++) begin
        conc <= cv[j];
        pulse(7'h08);
        tick(2);
        t = i[0] & (i[1] ? cv[j] < 16'h1000 : cv[j] > 16'h1000);
        `CHK("alarm1", t ^ i[2], a1)
        `CHK("alarm2", t ^ i[2], a2)
      end
    end
    cfg <= {4'h9, 16'h1000};
    conc <= 16'h2000;
    pulse(7'h08);
    tick(2);
    `CHK("alarm1", 1'b1, a1)
    conc <= 16'h0800;
    pulse(7'h08);
    tick(2);
    `CHK("alarm1", 1'b1, a1)
    ack <= 1'b1;
    tick(1);
    ack <= 1'b0;
    tick(2);
    `CHK("alarm1", 1'b0, a1)
    pulse(7'h10);
    tick(5);
    `CHK("sys", 1'b0, sys)
    pulse(7'h20);
    tick(2);
    `CHK("pwr", 1'b0, pwr)
    pulse(7'h20);
    tick(2);
    `CHK("pwr", 1'b0, pwr)
    pulse(7'h60);
    tick(2);
    `CHK("sys", 1'b1, sys)
    `CHK("pwr", 1'b1, pwr)
    command(CHR_R, CHR_H);
    `CHK("range", 3'h4, rng)
    command(CHR_R, CHR_M);
    `CHK("range", 3'h2, rng)
    command(CHR_R, CHR_L);
    `CHK("range", 3'h1, rng)
    command(CHR_A, CHR_S);
    `CHK("busy", 1'b1, busy)
    `CHK("spanvalve", 1'b1, spv)
    command(CHR_A, CHR_L);
    `CHK("busy", 1'b0, busy)
    close_out();
  end
endmodule
